//--- ssd_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// far-side serial source: toggling line seen through eight sub-phases
module ssd_far_end (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       send_i,
    input  wire logic [2:0] edge_i,
    output logic      [7:0] samples_o
);
    logic cur_q;
    logic prev_q;
    // transitions supplied
    // toggles every bit while sending, flat low line otherwise
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cur_q  <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            prev_q <= cur_q;
            cur_q  <= send_i ? ~cur_q : 1'b0;
        end
    end
    // data edge falls between sub-phase edge_i-1 and edge_i
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            samples_o[i] = (i < edge_i) ? prev_q : cur_q;
        end
    end
endmodule : ssd_far_end
`default_nettype wire

//--- ssd_pkg.sv
package ssd_pkg;
    typedef enum logic [1:0] {
        SSD_SER = 2'b00,
        SSD_DDR = 2'b01,
        SSD_SDR = 2'b10
    } ssd_txm_e;
    typedef struct packed {
        logic [18:0] rsv;
        logic        fwd_en;
        logic [2:0]  fwd_ph;
        logic [2:0]  fwd_div;
        ssd_txm_e    txm;
        logic [3:0]  txf;
    } ssd_ctrl_s;
    typedef struct packed {
        logic [19:0] rsv;
        logic        fifo_rst;
        logic        chan_rst;
        logic [3:0]  roll;
        logic        cdr;
        logic        byp;
        logic [3:0]  rxf;
    } ssd_rxcfg_s;
    typedef struct packed {
        logic locked;
        logic rollover;
    } ssd_rxstat_s;
    typedef struct packed {
        ssd_ctrl_s   ctrl;
        ssd_rxcfg_s  rxc;
        logic        ack;
        logic [31:0] rdata;
        logic [9:0]  tx_sh;
        logic [3:0]  tx_cnt;
        logic [6:0]  fe;
        logic [7:0]  fclk;
        logic [2:0]  ph;
        logic [3:0]  lcnt;
        logic        locked;
        logic        s7;
        logic [5:0]  mem;
        logic [2:0]  wp;
        logic [2:0]  rp;
        logic [10:0] hist;
        logic [3:0]  slip;
        logic        rflag;
        logic        al_prev;
        logic [8:0]  des;
        logic [3:0]  dcnt;
        logic [9:0]  rx_data;
        logic        rx_valid;
        logic        wclk;
    } ssd_st_s;
endpackage : ssd_pkg

//--- ssd_regs.svh
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH
`define SSD_CTRL_ADDR  4'h0
`define SSD_RXCFG_ADDR 4'h4
`define SSD_STAT_ADDR  4'h8
`define SSD_CTRL_RST   32'h0000_000a
`define SSD_RXCFG_RST  32'h0000_028a
`define SSD_LOCK_CNT   8
`define SSD_FIFO_DEP   6
`define SSD_FIFO_OFS   3
`define SSD_MAX_W      10
`endif

//--- ssd_serdes.sv
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_regs.svh"
module ssd_serdes #(
    parameter int LOCK_TRANS = `SSD_LOCK_CNT
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic [3:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    input  wire logic [3:0]         avs_byteenable_i,
    output logic [31:0]             avs_readdata_o,
    output logic                    avs_waitrequest_o,
    input  wire logic [9:0]         tx_data_i,
    output logic                    tx_load_o,
    output logic                    tx_serial_o,
    output logic [7:0]              tx_clk_o,
    input  wire logic [7:0]         rx_samples_i,
    input  wire logic               phase_hold_i,
    input  wire logic               pll_rst_i,
    input  wire logic               rx_align_i,
    output logic [9:0]              rx_data_o,
    output logic                    rx_valid_o,
    output logic                    forwarded_word_clock_o,
    output ssd_pkg::ssd_rxstat_s    rx_stat_o
);
    import ssd_pkg::*;

    ssd_st_s    q;
    ssd_st_s    d;
    logic [3:0] tf;
    logic [3:0] rf;
    logic [6:0] p8;
    logic       req;
    logic       ld;
    logic [3:0] edg;
    logic       rx_bit;
    logic       bit_in;
    logic [11:0] win;
    logic       chrst;
    logic       rise;

    // clamp a static factor to the legal three to ten range
    function automatic logic [3:0] fclamp(input logic [3:0] f);
        if (f < 4'd3) begin
            return 4'd3;
        end else if (f > 4'd10) begin
            return 4'd10;
        end
        return f;
    endfunction : fclamp

    // merge write data into a register under byte enables
    function automatic logic [31:0] bmerge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : bmerge

    // find the data edge among eight phase samples, bit 3 flags found
    function automatic logic [3:0] edge_at(input logic [7:0] s,
                                           input logic       p7);
        logic [3:0] r;
        r = 4'h0;
        if (p7 != s[0]) begin
            r = 4'h8;
        end else begin
            for (int i = 7; i >= 1; i--) begin
                if (s[i] != s[i-1]) begin
                    r = {1'b1, 3'(i)};
                end
            end
        end
        return r;
    endfunction : edge_at

    // effective factors and forwarded clock period in eighths
    // bypass factors
    always_comb begin
        case (q.ctrl.txm)
            SSD_SER: tf = fclamp(q.ctrl.txf);
            SSD_DDR: tf = 4'd2;
            SSD_SDR: tf = 4'd1;
            default: tf = 4'd1;
        endcase
        rf = q.rxc.byp ? 4'd2 : fclamp(q.rxc.rxf);
        case (q.ctrl.fwd_div)
            3'd1:    p8 = 7'd16;
            3'd2:    p8 = 7'd32;
            3'd3:    p8 = 7'd64;
            3'd4:    p8 = 7'd80;
            default: p8 = 7'd8;
        endcase
    end

    // datapath taps shared by next state and outputs
    assign req    = avs_read_i | avs_write_i;
    assign ld     = (q.tx_cnt == 4'd0);
    assign chrst  = q.rxc.chan_rst | pll_rst_i;
    assign edg    = edge_at(rx_samples_i, q.s7);
    assign rx_bit = rx_samples_i[q.rxc.byp ? 3'd0 : q.ph];
    assign bit_in = (q.rxc.cdr | q.rxc.byp) ? rx_bit : q.mem[q.rp];
    assign win    = {q.hist, bit_in};
    assign rise   = rx_align_i & ~q.al_prev;

    // next state of the whole block
    always_comb begin
        logic [7:0] t;
        logic [2:0] best;
        t    = 8'h00;
        best = 3'd0;
        d    = q;
        // bus slave, one wait state
        d.ack = req & ~q.ack;
        d.rxc.chan_rst = 1'b0;
        d.rxc.fifo_rst = 1'b0;
        if (req && !q.ack) begin
            case (avs_address_i)
                `SSD_CTRL_ADDR:  d.rdata = q.ctrl;
                `SSD_RXCFG_ADDR: d.rdata = q.rxc;
                `SSD_STAT_ADDR:  d.rdata = {23'h0, q.slip, q.ph,
                                            q.rflag, q.locked};
                default:         d.rdata = 32'h0;
            endcase
        end
        if (avs_write_i && q.ack) begin
            case (avs_address_i)
                `SSD_CTRL_ADDR:  d.ctrl = bmerge(q.ctrl, avs_writedata_i,
                                                avs_byteenable_i);
                `SSD_RXCFG_ADDR: d.rxc = bmerge(q.rxc, avs_writedata_i,
                                               avs_byteenable_i);
                default: ;
            endcase
            d.ctrl.rsv = '0;
            d.rxc.rsv  = '0;
        end
        if (ld) begin
            d.tx_sh = tx_data_i << (4'd10 - tf);
        end else begin
            d.tx_sh = q.tx_sh << 1;
        end
        d.tx_cnt = (q.tx_cnt >= tf - 4'd1) ? 4'd0 : q.tx_cnt + 4'd1;
        // forwarded clock in eighth steps
        // wrap to zero so a shorter period never leaves fe out of range
        d.fe = (q.fe + 7'd8 >= p8) ? 7'd0 : q.fe + 7'd8;
        for (int i = 0; i < 8; i++) begin
            t = {1'b0, d.fe} + 8'(i) + {1'b0, p8} - {5'h0, q.ctrl.fwd_ph};
            if (t >= {1'b0, p8}) begin
                t = t - {1'b0, p8};
            end
            if (t >= {1'b0, p8}) begin
                t = t - {1'b0, p8};
            end
            d.fclk[i] = (t < {2'b0, p8[6:1]});
        end
        d.s7 = rx_samples_i[7];
        best = edg[2:0] + 3'd4;
        if (chrst) begin
            d.ph     = 3'd0;
            d.lcnt   = 4'd0;
            d.locked = 1'b0;
        end else if (!q.rxc.byp && edg[3] && !phase_hold_i) begin
            if (best == q.ph) begin
                if (q.lcnt != 4'hf) begin
                    d.lcnt = q.lcnt + 4'd1;
                end
                if (q.lcnt >= 4'(LOCK_TRANS - 1)) begin
                    d.locked = 1'b1;
                end
            end else begin
                d.ph   = best;
                d.lcnt = 4'd0;
            end
        end
        // six deep fifo, fixed fill offset
        if (q.rxc.fifo_rst || chrst) begin
            d.mem = 6'h00;
            d.wp  = 3'(`SSD_FIFO_OFS);
            d.rp  = 3'd0;
        end else begin
            d.mem[q.wp] = rx_bit;
            d.wp = (q.wp == 3'(`SSD_FIFO_DEP - 1)) ? 3'd0 : q.wp + 3'd1;
            d.rp = (q.rp == 3'(`SSD_FIFO_DEP - 1)) ? 3'd0 : q.rp + 3'd1;
        end
        d.hist    = win[10:0];
        d.al_prev = rx_align_i;
        if (chrst) begin
            d.slip = 4'd0;
        end else if (rise && !q.rxc.byp) begin
            d.slip = (q.slip >= q.rxc.roll) ? 4'd0 : q.slip + 4'd1;
        end
        d.rflag = (d.slip == q.rxc.roll);
        d.des      = {q.des[7:0], q.rxc.byp ? bit_in : win[q.slip]};
        d.rx_valid = 1'b0;
        if (q.dcnt >= rf - 4'd1) begin
            d.dcnt     = 4'd0;
            d.rx_valid = 1'b1;
            d.rx_data  = {q.des, d.des[0]} & ~(10'h3ff << rf);
        end else begin
            d.dcnt = q.dcnt + 4'd1;
        end
        // word clock, data rate over factor
        d.wclk = (d.dcnt < {1'b0, rf[3:1]});
    end

    // register the whole state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q      <= '0;
            q.ctrl <= `SSD_CTRL_RST;
            q.rxc  <= `SSD_RXCFG_RST;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign avs_readdata_o         = q.rdata;
    assign avs_waitrequest_o      = req & ~q.ack;
    assign tx_load_o              = ld;
    assign tx_serial_o            = q.tx_sh[9];
    assign tx_clk_o               = q.ctrl.fwd_en ? q.fclk : 8'h00;
    assign rx_data_o              = q.rx_data;
    assign rx_valid_o             = q.rx_valid;
    assign forwarded_word_clock_o = q.wclk;
    assign rx_stat_o              = '{locked: q.locked, rollover: q.rflag};

    // first bit out is word msb
    property p_tx_msb;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_load_o && q.ctrl.txm == SSD_SER && $stable(tf)
        |=> tx_serial_o == $past(tx_data_i[tf - 4'd1]);
    endproperty
    a_tx_msb: assert property (p_tx_msb)
        else $error("first serial bit is not the word msb");

    property p_tx_load3;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_load_o && tf == 4'd3 ##1 tf == 4'd3 ##1 tf == 4'd3
        |-> !$past(tx_load_o) && !tx_load_o ##1 tx_load_o;
    endproperty
    a_tx_load3: assert property (p_tx_load3)
        else $error("load enable period does not follow factor three");

    property p_ddr_load;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_load_o && tf == 4'd2 ##1 tf == 4'd2 |-> !tx_load_o ##1 tx_load_o;
    endproperty
    a_ddr_load: assert property (p_ddr_load)
        else $error("ddr bypass does not reload every two bits");

    property p_fclk_ph;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        q.ctrl.fwd_en && q.ctrl.fwd_div == 3'd0 && $stable(q.ctrl)
        ##1 $stable(q.ctrl)
        |-> tx_clk_o == ($past(q.ctrl.fwd_ph) == 3'd0 ? 8'h0f :
                         $past(q.ctrl.fwd_ph) == 3'd4 ? 8'hf0 :
                         $past(q.ctrl.fwd_ph) == 3'd2 ? 8'h3c : tx_clk_o);
    endproperty
    a_fclk_ph: assert property (p_fclk_ph)
        else $error("forwarded clock phase pattern is wrong");

    property p_slip_inc;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rise && !q.rxc.byp && !chrst && q.slip < q.rxc.roll
        |=> q.slip == $past(q.slip) + 4'd1;
    endproperty
    a_slip_inc: assert property (p_slip_inc)
        else $error("align pulse did not add one bit of slip");

    property p_slip_roll;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rise && !q.rxc.byp && !chrst && q.slip == q.rxc.roll
        |=> q.slip == 4'd0 && !rx_stat_o.rollover;
    endproperty
    a_slip_roll: assert property (p_slip_roll)
        else $error("slip did not return to zero at rollover");

    property p_byp_slip;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        q.rxc.byp && !chrst |=> $stable(q.slip);
    endproperty
    a_byp_slip: assert property (p_byp_slip)
        else $error("slip moved with deserializer bypassed");

    property p_lock_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_stat_o.locked && !chrst |=> rx_stat_o.locked;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock dropped without a reset");

    property p_ph_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        phase_hold_i && !chrst |=> $stable(q.ph);
    endproperty
    a_ph_hold: assert property (p_ph_hold)
        else $error("phase changed while held");

    // word clock high with each word
    property p_wclk_word;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_valid_o |-> forwarded_word_clock_o;
    endproperty
    a_wclk_word: assert property (p_wclk_word)
        else $error("word clock low while a word is handed over");

    property p_roll_flag;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $stable(q.rxc.roll)
        |-> rx_stat_o.rollover == (q.slip == q.rxc.roll);
    endproperty
    a_roll_flag: assert property (p_roll_flag)
        else $error("rollover status disagrees with slip count");

    c_lock: cover property (@(posedge sys_clk_i) $rose(rx_stat_o.locked));
    c_roll: cover property (@(posedge sys_clk_i)
        $rose(rx_stat_o.rollover));
    c_word: cover property (@(posedge sys_clk_i)
        rx_valid_o && rf == 4'd10);
    c_cdr: cover property (@(posedge sys_clk_i) rx_valid_o && q.rxc.cdr);
    c_center: cover property (@(posedge sys_clk_i)
        q.ctrl.fwd_en && q.ctrl.fwd_ph == 3'd4);
endmodule : ssd_serdes
`default_nettype wire

//--- ssd_serdes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssd_serdes_tb;
    import ssd_pkg::*;
    logic        sys_clk_i       = 1'b0;
    logic        rst_n_i         = 1'b0;
    logic [3:0]  avs_address_i   = 4'h0;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [9:0]  tx_data_i       = 10'h2c6;
    logic        phase_hold_i    = 1'b0;
    logic        pll_rst_i       = 1'b0;
    logic        rx_align_i      = 1'b0;
    logic        send            = 1'b0;
    logic [2:0]  edge_pos        = 3'h2;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        tx_load_o;
    logic        tx_serial_o;
    logic [7:0]  tx_clk_o;
    logic [7:0]  rx_samples_i;
    logic [9:0]  rx_data_o;
    logic        rx_valid_o;
    logic        fwd_wclk;
    ssd_rxstat_s rx_stat_o;
    logic [31:0] rd;
    int          num_errors   = 0;
    int          total_checks = 0;
    ssd_serdes #(.LOCK_TRANS(2)) ssd_serdes_i (
        .sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
        .avs_waitrequest_o, .tx_data_i, .tx_load_o, .tx_serial_o,
        .tx_clk_o, .rx_samples_i, .phase_hold_i, .pll_rst_i, .rx_align_i,
        .rx_data_o, .rx_valid_o, .forwarded_word_clock_o(fwd_wclk),
        .rx_stat_o);
    ssd_far_end ssd_far_end_i (.sys_clk_i, .rst_n_i, .send_i(send),
        .edge_i(edge_pos), .samples_o(rx_samples_i));
    // 200 MHz clock
    always #2.5 sys_clk_i = ~sys_clk_i;
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input string w, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic guard(input int n);
        if (n >= 200) begin
            num_errors++;
            $display("Error wait expected answer seen none");
            give_verdict();
        end
    endtask : guard
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        logic busy;
        n = 0;
        @(posedge sys_clk_i);
        avs_read_i      <= ~w;
        avs_write_i     <= w;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        // waitrequest settles mid-cycle; the next rising edge completes
        do begin
            @(negedge sys_clk_i);
            busy = avs_waitrequest_o;
            @(posedge sys_clk_i);
            n++;
        end while (busy !== 1'b0 && n < 200);
        guard(n);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    function automatic logic pick(input int s);
        case (s)
            0: return tx_load_o;
            1: return rx_valid_o;
            default: return rx_stat_o.locked;
        endcase
    endfunction : pick
    task automatic wait_hi(input int s);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (pick(s) !== 1'b1 && n < 200);
        guard(n);
        @(posedge sys_clk_i);
    endtask : wait_hi
    task automatic gap(input int s, output int n);
        wait_hi(s);
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (pick(s) !== 1'b1 && n < 200);
        guard(n);
    endtask : gap
    task automatic pulse();
        @(posedge sys_clk_i);
        rx_align_i <= 1'b1;
        cyc(6);
        rx_align_i <= 1'b0;
        cyc(6);
    endtask : pulse
    task automatic t_regs();
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl reset", 32'ha, rd);
        bus(1'b0, 4'h4, 32'h0);
        chk("rxcfg reset", 32'h28a, rd);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 4'h8, 32'h3);
        bus(1'b0, 4'h8, 32'h0);
        chk("status flags", 32'h0, rd & 32'h3);
        $display("test regs done");
    endtask : t_regs
    task automatic t_tx();
        for (int t = 3; t <= 10; t += 7) begin
            bus(1'b1, 4'h0, t);
            wait_hi(0);
            wait_hi(0);
            for (int k = t - 1; k >= 0; k--) begin
                @(negedge sys_clk_i);
                chk("serial bit", tx_data_i[k], tx_serial_o);
            end
            chk("reload", 32'h1, tx_load_o);
        end
        $display("test tx done");
    endtask : t_tx
    task automatic t_mode();
        int n;
        bus(1'b1, 4'h0, 32'h1a);
        gap(0, n);
        chk("ddr load gap", 32'h2, n);
        bus(1'b1, 4'h0, 32'h2a);
        gap(0, n);
        chk("sdr load gap", 32'h1, n);
        $display("test modes done");
    endtask : t_mode
    task automatic t_fwd();
        logic [31:0] cfg[4] = '{32'h100a, 32'h180a, 32'h140a, 32'ha};
        logic [7:0]  exp[4] = '{8'h0f, 8'hf0, 8'h3c, 8'h00};
        logic [7:0]  seen;
        bus(1'b1, 4'h0, 32'h104a);
        cyc(3);
        @(negedge sys_clk_i);
        seen = tx_clk_o;
        @(negedge sys_clk_i);
        chk("fwd half rate", 32'hff, seen ^ tx_clk_o);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 4'h0, cfg[k]);
            cyc(3);
            chk("fwd clock", exp[k], tx_clk_o);
        end
        $display("test fwd done");
    endtask : t_fwd
    task automatic t_lock();
        int n;
        logic [9:0] w;
        bus(1'b1, 4'h4, 32'h84);
        cyc(30);
        chk("lock idle", 32'h0, rx_stat_o.locked);
        send <= 1'b1;
        wait_hi(2);
        bus(1'b1, 4'h4, 32'h884);
        bus(1'b0, 4'h8, 32'h0);
        chk("phase", 32'h6, rd[4:2]);
        phase_hold_i <= 1'b1;
        edge_pos     <= 3'h5;
        cyc(40);
        bus(1'b0, 4'h8, 32'h0);
        chk("held phase", 32'h6, rd[4:2]);
        phase_hold_i <= 1'b0;
        cyc(40);
        bus(1'b0, 4'h8, 32'h0);
        chk("new phase", 32'h1, rd[4:2]);
        gap(1, n);
        chk("word gap", 32'h4, n);
        // link judged by data, not lock
        w = rx_data_o ^ (rx_data_o >> 1);
        chk("word toggles", 32'h7, w & 10'h7);
        chk("word top", 32'h0, rx_data_o >> 4);
        n = 0;
        repeat (8) begin
            @(negedge sys_clk_i);
            n += int'(fwd_wclk);
        end
        chk("word clock", 32'h4, n);
        // cdr on, no channel reset while locked
        bus(1'b1, 4'h4, 32'ha4);
        edge_pos <= 3'h2;
        cyc(40);
        bus(1'b0, 4'h8, 32'h0);
        chk("cdr phase", 32'h6, rd[4:2]);
        gap(1, n);
        w = rx_data_o ^ (rx_data_o >> 1);
        chk("cdr word", 32'h7, w & 10'h7);
        bus(1'b1, 4'h4, 32'h84);
        $display("test lock done");
    endtask : t_lock
    task automatic t_slip();
        logic [3:0] es[3] = '{4'h1, 4'h2, 4'h0};
        for (int k = 0; k < 3; k++) begin
            pulse();
            bus(1'b0, 4'h8, 32'h0);
            chk("slip", es[k], rd[8:5]);
            chk("rollover", k == 1, rx_stat_o.rollover);
        end
        bus(1'b1, 4'h4, 32'h94);
        pulse();
        bus(1'b0, 4'h8, 32'h0);
        chk("bypass slip", 32'h0, rd[8:5]);
        bus(1'b1, 4'h4, 32'h84);
        $display("test slip done");
    endtask : t_slip
    task automatic t_clear();
        send <= 1'b1;
        wait_hi(2);
        send <= 1'b0;
        cyc(40);
        chk("lock kept", 32'h1, rx_stat_o.locked);
        bus(1'b1, 4'h4, 32'h484);
        cyc(4);
        chk("lock chan rst", 32'h0, rx_stat_o.locked);
        send <= 1'b1;
        wait_hi(2);
        send      <= 1'b0;
        pll_rst_i <= 1'b1;
        cyc(2);
        pll_rst_i <= 1'b0;
        cyc(2);
        chk("lock pll rst", 32'h0, rx_stat_o.locked);
        $display("test clear done");
    endtask : t_clear
    // main sequence after a 16-cycle reset
    initial begin
        cyc(16);
        rst_n_i <= 1'b1;
        t_regs();
        t_tx();
        t_mode();
        t_fwd();
        t_lock();
        t_slip();
        t_clear();
        give_verdict();
    end
endmodule : ssd_serdes_tb
`default_nettype wire
